// ---- sim/drp_host.sv ----
`default_nettype none
module drp_host
  import drp_pkg::*;
(
  input wire logic clk_i,
  output drp_reg_req_t req_o,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial req_o = '0;

  // Released lines show the inverse of the last value
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    #1;
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    #1;
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
    @(posedge clk_i);
    #1;
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_i);
    #1;
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hFFFFFFFF};
    v = rvalid_i;
    d = rdata_i;
  endtask

  // Two more writes push a value through the pipe
  task automatic flush(input logic [15:0] a, input logic [31:0] d);
    wr(a, d);
    wr(a, d);
  endtask

  task automatic prot(input logic on);
    wr(ADDR_PROT_KEY, {24'h0, PROT_KEY});
    wr(ADDR_PROT_CTRL, {24'h0, on ? PROT_ON : PROT_OFF});
  endtask

  function automatic logic [9:0] code(input int s);
    if (s > PHCAL_LIMIT) s = PHCAL_LIMIT;
    if (s < -PHCAL_LIMIT) s = -PHCAL_LIMIT;
    return (s <= 0) ? 10'(-s) : 10'(s + PHCAL_LAG_OFFSET);
  endfunction
endmodule
`default_nettype wire

// ---- sim/drp_top_asserts.sv ----
`default_nettype none
module drp_top_asserts
  import drp_pkg::*;
#(
  parameter int RATE_CYC = 50,
  parameter int DELAY_CYC = 2,
  parameter int LOW_CYC = 10
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic SW_RESET_I,
  // Watched ports
  input wire drp_reg_req_t REG_REQ_I,
  input wire logic REG_RVALID_O,
  input wire logic ZX_STATE_I,
  input wire logic DSP_RUN_O,
  input wire logic DONE_TICK_O,
  input wire logic INT0_N_O,
  input wire logic SHARED_PIN_O,
  input wire logic PROT_ON_O,
  input wire drp_phase_t PHASE_A_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] sel;
  logic [15:0] gap;
  logic [15:0] low_cnt;
  logic had;

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  // ---------------------------------------------------------------
  // Shadow of pin select, tick spacing and pin low time
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I || SW_RESET_I) begin
      sel <= PINSEL_DONE;
      gap <= '0;
      had <= 1'b0;
      low_cnt <= '0;
    end else begin
      if (REG_REQ_I.wr && REG_REQ_I.addr == ADDR_SETUP) begin
        sel <= REG_REQ_I.wdata[1:0];
      end
      low_cnt <= SHARED_PIN_O ? 16'h0 : low_cnt + 16'h1;
      if (!DSP_RUN_O) begin
        had <= 1'b0;
        gap <= '0;
      end else if (DONE_TICK_O) begin
        had <= 1'b1;
        gap <= 16'h1;
      end else begin
        gap <= gap + 16'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  rd_answer_a: assert property (
    REG_REQ_I.rd && !SW_RESET_I |=> REG_RVALID_O
  ) else $error("read not answered");
  tick_rate_a: assert property (
    DONE_TICK_O && had |-> gap == RATE_CYC && $past(DSP_RUN_O)
  ) else $error("done tick spacing wrong");
  int_release_a: assert property (
    REG_REQ_I.wr && REG_REQ_I.addr == ADDR_FLAGS0 && REG_REQ_I.wdata[DONE_BIT] &&
    !DONE_TICK_O && !SW_RESET_I |-> ##[1:2] INT0_N_O
  ) else $error("interrupt not released");
  pin_fall_a: assert property (
    $fell(SHARED_PIN_O) && sel == PINSEL_DONE && $past(sel) == PINSEL_DONE
    |-> $past(DONE_TICK_O, DELAY_CYC + 1)
  ) else $error("pin fell without done tick");
  pin_width_a: assert property (
    $rose(SHARED_PIN_O) && sel == PINSEL_DONE && $past(sel) == PINSEL_DONE &&
    !$past(SW_RESET_I) |-> low_cnt == LOW_CYC
  ) else $error("pin low time wrong");
  pin_follow_a: assert property (
    sel != PINSEL_DONE && $past(sel) != PINSEL_DONE |-> SHARED_PIN_O == $past(ZX_STATE_I)
  ) else $error("pin not following crossing");
  soft_reset_a: assert property (
    SW_RESET_I |-> ##2 (!DSP_RUN_O && INT0_N_O && !PROT_ON_O && PHASE_A_O == '0)
  ) else $error("soft reset state wrong");
  run_write_a: assert property (
    REG_REQ_I.wr && REG_REQ_I.addr == ADDR_RUN && !SW_RESET_I
    |=> DSP_RUN_O == ($past(REG_REQ_I.wdata[15:0]) == RUN_START)
  ) else $error("run state wrong after write");
  prot_cause_a: assert property (
    $changed(PROT_ON_O) && !$past(SW_RESET_I) && !$past(SW_RESET_I, 2) |->
    $past(REG_REQ_I.wr && REG_REQ_I.addr == ADDR_PROT_CTRL) ||
    $past(REG_REQ_I.wr && REG_REQ_I.addr == ADDR_PROT_CTRL, 2)
  ) else $error("protection changed without control write");
  phase_dec_a: assert property (
    REG_REQ_I.wr && REG_REQ_I.addr == ADDR_PHCAL_A && !SW_RESET_I
    |=> PHASE_A_O == $past(REG_REQ_I.wdata[9:0])
  ) else $error("phase decode wrong");
endmodule

bind drp_top drp_top_asserts #(
  .RATE_CYC(RATE_CYC),
  .DELAY_CYC(DELAY_CYC),
  .LOW_CYC(LOW_CYC)
) u_chk (
  .SYS_CLK_I(SYS_CLK_I),
  .RSTN_I(RSTN_I),
  .SW_RESET_I(SW_RESET_I),
  .REG_REQ_I(REG_REQ_I),
  .REG_RVALID_O(REG_RVALID_O),
  .ZX_STATE_I(ZX_STATE_I),
  .DSP_RUN_O(DSP_RUN_O),
  .DONE_TICK_O(DONE_TICK_O),
  .INT0_N_O(INT0_N_O),
  .SHARED_PIN_O(SHARED_PIN_O),
  .PROT_ON_O(PROT_ON_O),
  .PHASE_A_O(PHASE_A_O)
);
`default_nettype wire

// ---- sim/test_dsp_run_ram_protect_ctrl.sv ----
`default_nettype none
module test_dsp_run_ram_protect_ctrl
  import drp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RATE = 60;
  localparam int DLY = 2;
  localparam int LOW = 10;
  logic clk, rstn, sw_rst, zx, run, tick, int_n, pin, prot, rvalid;
  logic [31:0] rdata, x, y;
  drp_reg_req_t req;
  drp_phase_t ph_a, ph_b, ph_c, ph;
  int fail_count, n_checks, seed, s, k;
  int corner [3] = '{383, -383, 0};
  logic [15:0] rst_addr [8] = '{ADDR_RUN, ADDR_RAM_FIRST, ADDR_RAM_LAST, ADDR_PROT_CTRL,
    ADDR_PROT_KEY, 16'h1234, ADDR_FLAGS0, ADDR_PHCAL_C};

  drp_top #(.RATE_CYC(RATE), .DELAY_CYC(DLY), .LOW_CYC(LOW)) u_dut (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .SW_RESET_I(sw_rst), .REG_REQ_I(req),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .ZX_STATE_I(zx), .DSP_RUN_O(run),
    .DONE_TICK_O(tick), .INT0_N_O(int_n), .SHARED_PIN_O(pin), .PROT_ON_O(prot),
    .PHASE_A_O(ph_a), .PHASE_B_O(ph_b), .PHASE_C_O(ph_c)
  );
  drp_host u_host (.clk_i(clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] ram(input logic [31:0] d);
    return {4'h0, d[27:0]};
  endfunction
  function automatic logic [31:0] exp_ph(input int v);
    return (v <= 0) ? 32'(-v) : 32'(v + 512);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic v;
    u_host.rd(a, d, v);
    chk("rvalid", 32'h1, {31'h0, v});
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic wait_tick;
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (tick !== 1'b1 && k < 3 * RATE);
    chk("tick", 32'h1, {31'h0, tick});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = 32'hb440;
    fail_count = 0;
    n_checks = 0;
    rstn = 1'b0;
    sw_rst = 1'b0;
    zx = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    foreach (rst_addr[i]) rchk(rst_addr[i], 32'h0);
    $display("test reset done");
    x = $random(seed);
    y = $random(seed);
    u_host.wr(ADDR_RAM_FIRST, x);
    u_host.wr(ADDR_RAM_LAST, y);
    rchk(ADDR_RAM_FIRST, 32'h0);
    u_host.wr(ADDR_RAM_LAST, y);
    rchk(ADDR_RAM_FIRST, ram(x));
    rchk(ADDR_RAM_LAST, 32'h0);
    u_host.wr(ADDR_RAM_LAST, y);
    rchk(ADDR_RAM_LAST, ram(y));
    $display("test pipeline done");
    for (int i = 0; i < 12; i++) begin
      s = (i < 3) ? corner[i] : $random(seed) % 384;
      u_host.wr(ADDR_PHCAL_A + 16'(i % 3), {22'h0, u_host.code(s)});
      rchk(ADDR_PHCAL_A + 16'(i % 3), exp_ph(s));
      ph = (i % 3 == 0) ? ph_a : ((i % 3 == 1) ? ph_b : ph_c);
      chk("phase port", exp_ph(s), {22'h0, ph});
    end
    $display("test phase done");
    u_host.prot(1'b1);
    rchk(ADDR_PROT_CTRL, 32'h80);
    chk("prot pin", 32'h1, {31'h0, prot});
    repeat (3) u_host.wr(ADDR_RAM_FIRST, ~x);
    rchk(ADDR_RAM_FIRST, ram(x));
    u_host.wr(ADDR_PROT_KEY, 32'hAD);
    u_host.wr(ADDR_SETUP, 32'h0);
    u_host.wr(ADDR_PROT_CTRL, 32'h0);
    rchk(ADDR_PROT_CTRL, 32'h80);
    u_host.prot(1'b0);
    rchk(ADDR_PROT_CTRL, 32'h0);
    chk("prot pin", 32'h0, {31'h0, prot});
    u_host.wr(ADDR_RAM_FIRST, y);
    u_host.flush(ADDR_RAM_FIRST, y);
    rchk(ADDR_RAM_FIRST, ram(y));
    $display("test protection done");
    u_host.wr(ADDR_ENABLE0, 32'h1 << DONE_BIT);
    u_host.wr(ADDR_RUN, 32'(RUN_START));
    chk("run", 32'h1, {31'h0, run});
    wait_tick();
    wait_tick();
    cyc(1);
    chk("int", 32'h0, {31'h0, int_n});
    rchk(ADDR_FLAGS0, 32'h1 << DONE_BIT);
    u_host.wr(ADDR_FLAGS0, 32'h0);
    rchk(ADDR_FLAGS0, 32'h1 << DONE_BIT);
    u_host.wr(ADDR_FLAGS0, 32'h1 << DONE_BIT);
    cyc(1);
    chk("int", 32'h1, {31'h0, int_n});
    rchk(ADDR_FLAGS0, 32'h0);
    u_host.wr(ADDR_ENABLE0, 32'h0);
    wait_tick();
    cyc(1);
    chk("int", 32'h1, {31'h0, int_n});
    cyc(DLY);
    chk("pin", 32'h0, {31'h0, pin});
    cyc(LOW - 1);
    chk("pin", 32'h0, {31'h0, pin});
    cyc(1);
    chk("pin", 32'h1, {31'h0, pin});
    x = $random(seed);
    repeat (3) u_host.wr(ADDR_RAM_LAST, x);
    rchk(ADDR_RAM_LAST, ram(x));
    chk("run", 32'h1, {31'h0, run});
    u_host.wr(ADDR_RUN, 32'(RUN_STOP));
    k = 0;
    repeat (2 * RATE) begin
      cyc(1);
      k += int'(tick === 1'b1);
    end
    chk("ticks", 32'h0, 32'(k));
    u_host.wr(ADDR_RUN, 32'(RUN_START));
    wait_tick();
    $display("test run done");
    for (int m = 1; m < 4; m++) begin
      u_host.wr(ADDR_SETUP, 32'(m));
      repeat (8) begin
        zx = $random(seed);
        cyc(2);
        chk("pin", {31'h0, zx}, {31'h0, pin});
      end
      zx = 1'b1;
      cyc(2);
    end
    // Return to the done pulse right after a tick, before its low phase starts
    wait_tick();
    u_host.wr(ADDR_SETUP, 32'h0);
    $display("test pin select done");
    u_host.prot(1'b1);
    cyc(1);
    sw_rst = 1'b1;
    cyc(1);
    sw_rst = 1'b0;
    rchk(ADDR_RUN, 32'h0);
    rchk(ADDR_RAM_LAST, 32'h0);
    rchk(ADDR_PROT_CTRL, 32'h0);
    chk("prot pin", 32'h0, {31'h0, prot});
    $display("test soft reset done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- verilog/drp_interval.sv ----
`default_nettype none
module drp_interval #(
  parameter int PERIOD = 25000
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  // Control
  input wire logic clr_i,
  input wire logic run_i,
  // Tick
  output logic tick_o
);

  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_tick;

  // ---------------------------------------------------------------
  // Period counter
  // ---------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (clr_i || !run_i) begin
      next_cnt = '0;
    end else if (cnt == LAST) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/drp_pkg.sv ----
`default_nettype none
package drp_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_RUN = 16'hE228;
  localparam logic [15:0] ADDR_FLAGS0 = 16'hE502;
  localparam logic [15:0] ADDR_ENABLE0 = 16'hE50A;
  localparam logic [15:0] ADDR_SETUP = 16'hE618;
  localparam logic [15:0] ADDR_PROT_CTRL = 16'hE7E3;
  localparam logic [15:0] ADDR_PROT_KEY = 16'hE7FE;
  localparam logic [15:0] ADDR_PHCAL_A = 16'hE7F0;
  localparam logic [15:0] ADDR_PHCAL_B = 16'hE7F1;
  localparam logic [15:0] ADDR_PHCAL_C = 16'hE7F2;
  localparam logic [15:0] ADDR_RAM_FIRST = 16'h4380;
  localparam logic [15:0] ADDR_RAM_LAST = 16'h43BF;

  // ---------------------------------------------------------------
  // Field layout and values
  // ---------------------------------------------------------------
  localparam int RAM_WIDTH = 28;
  localparam int RAM_DEPTH = 64;
  localparam int RAM_IDX_W = 6;
  localparam int DONE_BIT = 17;
  localparam int PHCAL_W = 10;
  localparam int PHCAL_LAG_BIT = 9;
  localparam int PHCAL_MAG_W = 9;
  localparam int PHCAL_WORD_W = 16;
  localparam int PINSEL_W = 2;
  localparam logic [15:0] RUN_START = 16'h0001;
  localparam logic [15:0] RUN_STOP = 16'h0000;
  localparam logic [15:0] RUN_RESET = 16'h0000;
  localparam logic [7:0] PROT_KEY = 8'hAD;
  localparam logic [7:0] PROT_ON = 8'h80;
  localparam logic [7:0] PROT_OFF = 8'h00;
  localparam logic [1:0] PINSEL_DONE = 2'h0;
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam int PHCAL_LIMIT = 383;
  localparam int PHCAL_LAG_OFFSET = 512;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int DSP_RATE_HZ = 8000;
  localparam int DSP_PERIOD_CYC = SYS_CLK_HZ / DSP_RATE_HZ;
  localparam int PIN_DELAY_NS = 70;
  localparam int PIN_DELAY_CYC = (PIN_DELAY_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
  localparam int PIN_LOW_NS = 10_000;
  localparam int PIN_LOW_CYC = (PIN_LOW_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PROC_CLK_HZ = 1_024_000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } drp_reg_req_t;

  typedef struct packed {
    logic lag;
    logic [PHCAL_MAG_W-1:0] steps;
  } drp_phase_t;

  typedef enum logic [1:0] {
    PIN_IDLE,
    PIN_WAIT,
    PIN_LOW
  } drp_pin_state_t;

endpackage
`default_nettype wire

// ---- verilog/drp_top.sv ----
// Summary of operation
// - Lagging correction carries 512 offset flag
// - Phase calibration read as zero-padded 16 bits
// - Pass every 8 kHz sets done flag
// - Enabled done flag drives interrupt low
// - Write one clears done flag, releases interrupt
// - Select 00: pin pulses low 10 us
// - Other selects route zero-crossing to pin
// - Input RAM 28 bits at 0x4380-0x43BF
// - RAM writes commit after two further writes
// - Reset: idle, RAM zero, run cleared
// - Run value 0x0001 starts execution
// - Run value 0x0000 stops execution
// - Protection off by default, blocks RAM writes
// - Key then 0x80 enables protection
// - Key then 0x00 disables protection
// - Registers writable while DSP runs
// - One step equals one processing clock period
`default_nettype none
module drp_top
  import drp_pkg::*;
#(
  parameter int RATE_CYC = DSP_PERIOD_CYC,
  parameter int DELAY_CYC = PIN_DELAY_CYC,
  parameter int LOW_CYC = PIN_LOW_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic SW_RESET_I,
  // Register access from the serial port
  input wire drp_reg_req_t REG_REQ_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // Zero-crossing indication from the detector
  input wire logic ZX_STATE_I,
  // Status and pins
  output logic DSP_RUN_O,
  output logic DONE_TICK_O,
  output logic INT0_N_O,
  output logic SHARED_PIN_O,
  output logic PROT_ON_O,
  // Datapath settings
  output drp_phase_t PHASE_A_O,
  output drp_phase_t PHASE_B_O,
  output drp_phase_t PHASE_C_O
);

  localparam int PCW = $clog2(((DELAY_CYC > LOW_CYC) ? DELAY_CYC : LOW_CYC) + 1);
  localparam logic [PCW-1:0] DELAY_LAST = PCW'((DELAY_CYC > 1) ? DELAY_CYC - 1 : 0);
  localparam logic [PCW-1:0] LOW_LAST = PCW'(LOW_CYC - 1);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic wr;
  logic rd;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic ram_hit;
  logic [RAM_IDX_W-1:0] ram_idx;

  assign wr = REG_REQ_I.wr;
  assign rd = REG_REQ_I.rd;
  assign addr = REG_REQ_I.addr;
  assign wdata = REG_REQ_I.wdata;
  assign ram_hit = (addr >= ADDR_RAM_FIRST) && (addr <= ADDR_RAM_LAST);
  assign ram_idx = addr[RAM_IDX_W-1:0];

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [15:0] run_reg;
  logic [31:0] enable0;
  logic [15:0] setup;
  logic [PHCAL_W-1:0] phcal [3];
  logic key_armed;
  logic prot;
  logic [15:0] next_run_reg;
  logic [31:0] next_enable0;
  logic [15:0] next_setup;
  logic [PHCAL_W-1:0] next_phcal [3];
  logic next_key_armed;
  logic next_prot;

  always_comb begin
    next_run_reg = run_reg;
    next_enable0 = enable0;
    next_setup = setup;
    next_phcal = phcal;
    next_key_armed = key_armed;
    next_prot = prot;
    if (SW_RESET_I) begin
      next_run_reg = RUN_RESET;
      next_enable0 = ENABLE_RESET;
      next_setup = SETUP_RESET;
      next_phcal = '{default: '0};
      next_key_armed = 1'b0;
      next_prot = 1'b0;
    end else if (wr) begin
      // Any write other than the key disarms the unlock
      next_key_armed = (addr == ADDR_PROT_KEY) && (wdata[7:0] == PROT_KEY);
      case (addr)
        ADDR_RUN: begin
          next_run_reg = wdata[15:0];
        end
        ADDR_ENABLE0: begin
          next_enable0 = wdata;
        end
        ADDR_SETUP: begin
          next_setup = wdata[15:0];
        end
        ADDR_PROT_CTRL: begin
          if (key_armed && wdata[7:0] == PROT_ON) begin
            next_prot = 1'b1;
          end else if (key_armed && wdata[7:0] == PROT_OFF) begin
            next_prot = 1'b0;
          end
        end
        ADDR_PHCAL_A: begin
          next_phcal[0] = wdata[PHCAL_W-1:0];
        end
        ADDR_PHCAL_B: begin
          next_phcal[1] = wdata[PHCAL_W-1:0];
        end
        ADDR_PHCAL_C: begin
          next_phcal[2] = wdata[PHCAL_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      run_reg <= RUN_RESET;
      enable0 <= ENABLE_RESET;
      setup <= SETUP_RESET;
      phcal <= '{default: '0};
      key_armed <= 1'b0;
      prot <= 1'b0;
    end else begin
      run_reg <= next_run_reg;
      enable0 <= next_enable0;
      setup <= next_setup;
      phcal <= next_phcal;
      key_armed <= next_key_armed;
      prot <= next_prot;
    end
  end

  // Only the start value runs the program; anything else leaves it idle
  assign DSP_RUN_O = (run_reg == RUN_START);
  assign PROT_ON_O = prot;

  // ---------------------------------------------------------------
  // Data RAM with two-stage write pipeline
  // ---------------------------------------------------------------
  logic [RAM_WIDTH-1:0] ram [RAM_DEPTH];
  logic [RAM_WIDTH-1:0] next_ram [RAM_DEPTH];
  logic st1_vld;
  logic st2_vld;
  logic [RAM_IDX_W-1:0] st1_idx;
  logic [RAM_IDX_W-1:0] st2_idx;
  logic [RAM_WIDTH-1:0] st1_dat;
  logic [RAM_WIDTH-1:0] st2_dat;
  logic next_st1_vld;
  logic next_st2_vld;
  logic [RAM_IDX_W-1:0] next_st1_idx;
  logic [RAM_IDX_W-1:0] next_st2_idx;
  logic [RAM_WIDTH-1:0] next_st1_dat;
  logic [RAM_WIDTH-1:0] next_st2_dat;
  logic ram_wr;

  assign ram_wr = wr && ram_hit && !prot && !SW_RESET_I;

  always_comb begin
    next_ram = ram;
    next_st1_vld = st1_vld;
    next_st2_vld = st2_vld;
    next_st1_idx = st1_idx;
    next_st2_idx = st2_idx;
    next_st1_dat = st1_dat;
    next_st2_dat = st2_dat;
    if (SW_RESET_I) begin
      next_ram = '{default: '0};
      next_st1_vld = 1'b0;
      next_st2_vld = 1'b0;
    end else if (ram_wr) begin
      // Each accepted write advances the pipe one place
      if (st2_vld) begin
        next_ram[st2_idx] = st2_dat;
      end
      next_st2_vld = st1_vld;
      next_st2_idx = st1_idx;
      next_st2_dat = st1_dat;
      next_st1_vld = 1'b1;
      next_st1_idx = ram_idx;
      next_st1_dat = wdata[RAM_WIDTH-1:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ram <= '{default: '0};
      st1_vld <= 1'b0;
      st2_vld <= 1'b0;
      st1_idx <= '0;
      st2_idx <= '0;
      st1_dat <= '0;
      st2_dat <= '0;
    end else begin
      ram <= next_ram;
      st1_vld <= next_st1_vld;
      st2_vld <= next_st2_vld;
      st1_idx <= next_st1_idx;
      st2_idx <= next_st2_idx;
      st1_dat <= next_st1_dat;
      st2_dat <= next_st2_dat;
    end
  end

  // ---------------------------------------------------------------
  // Computation rate and done flag
  // ---------------------------------------------------------------
  logic done_tick;
  logic done_flag;
  logic int0_n;
  logic next_done_flag;
  logic next_int0_n;
  logic flag_clr;

  drp_interval #(
    .PERIOD(RATE_CYC)
  ) u_rate (
    .SYS_CLK_I(SYS_CLK_I),
    .RSTN_I(RSTN_I),
    .clr_i(SW_RESET_I),
    .run_i(DSP_RUN_O),
    .tick_o(done_tick)
  );

  assign flag_clr = wr && (addr == ADDR_FLAGS0) && wdata[DONE_BIT];

  always_comb begin
    next_done_flag = done_tick || (done_flag && !flag_clr);
    if (SW_RESET_I) begin
      next_done_flag = 1'b0;
    end
    next_int0_n = !(next_done_flag && next_enable0[DONE_BIT]);
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      done_flag <= 1'b0;
      int0_n <= 1'b1;
    end else begin
      done_flag <= next_done_flag;
      int0_n <= next_int0_n;
    end
  end

  assign INT0_N_O = int0_n;
  assign DONE_TICK_O = done_tick;

  // ---------------------------------------------------------------
  // Shared done / zero-crossing pin
  // ---------------------------------------------------------------
  drp_pin_state_t pin_st;
  drp_pin_state_t next_pin_st;
  logic [PCW-1:0] pin_cnt;
  logic [PCW-1:0] next_pin_cnt;
  logic pin;
  logic next_pin;

  always_comb begin
    next_pin_st = pin_st;
    next_pin_cnt = pin_cnt;
    case (pin_st)
      PIN_IDLE: begin
        if (done_tick) begin
          next_pin_st = PIN_WAIT;
          next_pin_cnt = '0;
        end
      end
      PIN_WAIT: begin
        if (pin_cnt == DELAY_LAST) begin
          next_pin_st = PIN_LOW;
          next_pin_cnt = '0;
        end else begin
          next_pin_cnt = pin_cnt + PCW'(1);
        end
      end
      PIN_LOW: begin
        if (pin_cnt == LOW_LAST) begin
          next_pin_st = PIN_IDLE;
          next_pin_cnt = '0;
        end else begin
          next_pin_cnt = pin_cnt + PCW'(1);
        end
      end
      default: begin
        next_pin_st = PIN_IDLE;
        next_pin_cnt = '0;
      end
    endcase
    if (SW_RESET_I) begin
      next_pin_st = PIN_IDLE;
      next_pin_cnt = '0;
    end
    if (next_setup[PINSEL_W-1:0] == PINSEL_DONE) begin
      next_pin = (next_pin_st != PIN_LOW);
    end else begin
      next_pin = ZX_STATE_I;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pin_st <= PIN_IDLE;
      pin_cnt <= '0;
      pin <= 1'b1;
    end else begin
      pin_st <= next_pin_st;
      pin_cnt <= next_pin_cnt;
      pin <= next_pin;
    end
  end

  assign SHARED_PIN_O = pin;

  // ---------------------------------------------------------------
  // Phase calibration decode
  // ---------------------------------------------------------------
  // Each step is one processing clock period of delay (lag) or advance
  assign PHASE_A_O = '{lag: phcal[0][PHCAL_LAG_BIT], steps: phcal[0][PHCAL_MAG_W-1:0]};
  assign PHASE_B_O = '{lag: phcal[1][PHCAL_LAG_BIT], steps: phcal[1][PHCAL_MAG_W-1:0]};
  assign PHASE_C_O = '{lag: phcal[2][PHCAL_LAG_BIT], steps: phcal[2][PHCAL_MAG_W-1:0]};

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic rvalid;

  always_comb begin
    next_rdata = '0;
    if (ram_hit) begin
      next_rdata = {{(32 - RAM_WIDTH){1'b0}}, ram[ram_idx]};
    end else begin
      case (addr)
        ADDR_RUN: begin
          next_rdata = {16'h0000, run_reg};
        end
        ADDR_FLAGS0: begin
          next_rdata[DONE_BIT] = done_flag;
        end
        ADDR_ENABLE0: begin
          next_rdata = enable0;
        end
        ADDR_SETUP: begin
          next_rdata = {16'h0000, setup};
        end
        ADDR_PROT_CTRL: begin
          next_rdata = {24'h000000, (prot ? PROT_ON : PROT_OFF)};
        end
        ADDR_PHCAL_A: begin
          next_rdata = {16'h0000, (PHCAL_WORD_W - PHCAL_W)'(0), phcal[0]};
        end
        ADDR_PHCAL_B: begin
          next_rdata = {16'h0000, (PHCAL_WORD_W - PHCAL_W)'(0), phcal[1]};
        end
        ADDR_PHCAL_C: begin
          next_rdata = {16'h0000, (PHCAL_WORD_W - PHCAL_W)'(0), phcal[2]};
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata <= '0;
      rvalid <= 1'b0;
    end else begin
      rdata <= rd ? next_rdata : rdata;
      rvalid <= rd;
    end
  end

  assign REG_RDATA_O = rdata;
  assign REG_RVALID_O = rvalid;

endmodule
`default_nettype wire
